//--- core/cbted_core.sv
// Notes on behaviour
// - Config registers writable only in config mode
// - Quantum is two times prescale-plus-one clocks
// - Jump width code 00..11 means 1..4
// - Register two holds propagation and phase-one
// - Triple sampling takes majority of three
// - Phase-two from field or max(phase-one, two)
// - Phase-two field plus one, one to eight; field value not clamped, field 000 gives one
// - Clock pin shows start-of-frame or divided clock
// - Wake glitch filter enable bit
// - Receiver CRC mismatch flags error
// - Transmitter missing acknowledge flags error
// - Dominant in fixed-form fields flags error
// - Readback differing from driven flags bit error
// - Arbitration and acknowledge dominant readback exempt
// - Six equal bits flag stuff error
// - Any error sends error frame, retransmits only while transmitting
// - Error-active sends dominant error frames
// - Error-passive sends recessive error frames
// - Bus-off neither receives nor transmits
// - Sync segment is one quantum
// - Resync adjusts by at most jump width
// - Hard sync only on idle falling edge
// - Passive at 128, bus-off above 255
`include "cbted_regs.svh"
module cbted_core
  import cbted_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cfg_mode,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic bus_rx_pin,
  output logic bus_tx_pin,
  input wire cbted_frame_t frame,
  input wire logic [8:0] tx_error_count,
  input wire logic [7:0] rx_error_count,
  input wire logic clock_out_en,
  output logic clock_out_pin,
  output logic sample_strobe,
  output logic rx_bit,
  output cbted_err_t err_flags,
  output logic err_frame_req,
  output logic retransmit_req,
  output cbted_node_t node_state,
  output logic wake_event
);
  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] cfg1_reg, cfg2_reg, cfg3_reg;

  // Writes land only in configuration mode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg1_reg <= `CBTED_CFG_RESET;
      cfg2_reg <= `CBTED_CFG_RESET;
      cfg3_reg <= `CBTED_CFG_RESET;
    end else if (reg_wr && cfg_mode) begin
      case (reg_addr)
        `CBTED_CFG1_ADDR: cfg1_reg <= reg_wdata;
        `CBTED_CFG2_ADDR: cfg2_reg <= reg_wdata;
        `CBTED_CFG3_ADDR: cfg3_reg <= reg_wdata & `CBTED_CFG3_MASK;
        default: ;
      endcase
    end
  end

  // Registered read data, unmapped reads zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `CBTED_CFG1_ADDR: reg_rdata <= cfg1_reg;
        `CBTED_CFG2_ADDR: reg_rdata <= cfg2_reg;
        `CBTED_CFG3_ADDR: reg_rdata <= cfg3_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Decoded timing fields
  // ****************************************
  logic [6:0] half_len;
  logic [4:0] sjw_len, prop_len, ph1_len, ph2_field_len, ps2_base, tseg1_len, ps2_len;
  logic [4:0] ext_reg, shrink_reg;
  logic triple_sel, ph2_src, wake_filt_en, sof_sel;

  assign half_len = {1'b0, cfg1_reg[`CBTED_PRESCALE_LSB +: 6]} + 7'h01;
  assign sjw_len = {3'h0, cfg1_reg[`CBTED_SJW_LSB +: 2]} + 5'h01;
  assign prop_len = {2'h0, cfg2_reg[`CBTED_PROP_LSB +: 3]} + 5'h01;
  assign ph1_len = {2'h0, cfg2_reg[`CBTED_PH1_LSB +: 3]} + 5'h01;
  assign ph2_field_len = {2'h0, cfg3_reg[`CBTED_PH2_LSB +: 3]} + 5'h01;
  assign triple_sel = cfg2_reg[`CBTED_TRIPLE_BIT];
  assign ph2_src = cfg2_reg[`CBTED_PH2SRC_BIT];
  assign wake_filt_en = cfg3_reg[`CBTED_WAKEFILT_BIT];
  assign sof_sel = cfg3_reg[`CBTED_SOFSEL_BIT];
  // Phase-two source select
  assign ps2_base = ph2_src ? ph2_field_len :
                    ((ph1_len > `CBTED_IPT_TQ) ? ph1_len : `CBTED_IPT_TQ);
  assign tseg1_len = prop_len + ph1_len + ext_reg;
  // Software keeps phase-two above jump width, so no underflow
  assign ps2_len = ps2_base - shrink_reg;

  // ****************************************
  // Receive pin synchroniser and wake filter
  // ****************************************
  logic rx_s1, rx_s2, rx_s3, rx_level, rx_level_d;
  logic [2:0] wake_cnt;

  // Level changes once second and third stages agree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_level <= 1'b1;
      rx_level_d <= 1'b1;
    end else begin
      rx_s1 <= bus_rx_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      rx_level_d <= rx_level;
      if (rx_s2 == rx_s3) begin
        rx_level <= rx_s3;
      end
    end
  end

  // Wake pulse, filtered needs a dominant run
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_cnt <= 3'h0;
      wake_event <= 1'b0;
    end else begin
      wake_cnt <= rx_level ? 3'h0 :
                  ((wake_cnt == `CBTED_WAKE_FILT_CYC) ? wake_cnt : wake_cnt + 3'h1);
      if (wake_filt_en) begin
        wake_event <= !rx_level && (wake_cnt == `CBTED_WAKE_FILT_CYC - 3'h1);
      end else begin
        wake_event <= rx_level_d && !rx_level;
      end
    end
  end

  // ****************************************
  // Quantum prescaler and bit segments
  // ****************************************
  logic [6:0] pre_cnt;
  logic half_tick, tq_tick, rx_fall, hard_sync, edge_pend, synced_reg, last_bit;
  logic [1:0] hist_reg;
  logic [4:0] seg_cnt;
  cbted_seg_t seg_reg;
  logic smp_fire, smp_val;

  assign rx_fall = rx_level_d && !rx_level;
  assign tq_tick = (pre_cnt == {half_len[5:0], 1'b0} - 7'h01);
  assign half_tick = tq_tick || (pre_cnt == half_len - 7'h01);
  assign hard_sync = frame.bus_idle && rx_fall && last_bit;
  assign smp_fire = tq_tick && (seg_reg == SEG_TSEG1) && (seg_cnt == tseg1_len - 5'h01);
  // Majority of two half-quantum samples and the sample point
  assign smp_val = triple_sel ?
    ((hist_reg[1] & hist_reg[0]) | (hist_reg[1] & rx_level) | (hist_reg[0] & rx_level)) :
    rx_level;

  // Prescaler restarts on hard sync
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt <= 7'h00;
    end else if (hard_sync || tq_tick) begin
      pre_cnt <= 7'h00;
    end else begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  // Half-quantum history for triple sampling
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_reg <= 2'b11;
    end else if (half_tick) begin
      hist_reg <= {hist_reg[0], rx_level};
    end
  end

  // Pending edge, a new edge wins over the clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_pend <= 1'b0;
    end else if (rx_fall) begin
      edge_pend <= 1'b1;
    end else if (tq_tick || hard_sync) begin
      edge_pend <= 1'b0;
    end
  end

  // Segment sequencer with resynchronisation
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      seg_reg <= SEG_SYNC;
      seg_cnt <= 5'h00;
      ext_reg <= 5'h00;
      shrink_reg <= 5'h00;
      synced_reg <= 1'b0;
    end else if (hard_sync) begin
      seg_reg <= SEG_SYNC;
      seg_cnt <= 5'h00;
      ext_reg <= 5'h00;
      shrink_reg <= 5'h00;
      synced_reg <= 1'b1;
    end else if (tq_tick) begin
      case (seg_reg)
        SEG_SYNC: begin
          seg_reg <= SEG_TSEG1;
          seg_cnt <= 5'h00;
          if (edge_pend && last_bit) begin
            synced_reg <= 1'b1;
          end
        end
        SEG_TSEG1: begin
          if (edge_pend && last_bit && !synced_reg && !frame.tx_active) begin
            synced_reg <= 1'b1;
            ext_reg <= (seg_cnt + 5'h01 > sjw_len) ? sjw_len : seg_cnt + 5'h01;
          end
          if (seg_cnt >= tseg1_len - 5'h01) begin
            seg_reg <= SEG_PS2;
            seg_cnt <= 5'h00;
          end else begin
            seg_cnt <= seg_cnt + 5'h01;
          end
        end
        SEG_PS2: begin
          if (edge_pend && last_bit && !synced_reg && (ps2_len - seg_cnt <= sjw_len)) begin
            seg_reg <= SEG_TSEG1;
            seg_cnt <= 5'h00;
            ext_reg <= 5'h00;
            shrink_reg <= 5'h00;
            synced_reg <= 1'b1;
          end else if (seg_cnt >= ps2_len - 5'h01) begin
            seg_reg <= SEG_SYNC;
            seg_cnt <= 5'h00;
            ext_reg <= 5'h00;
            shrink_reg <= 5'h00;
            synced_reg <= 1'b0;
          end else begin
            if (edge_pend && last_bit && !synced_reg) begin
              shrink_reg <= sjw_len;
              synced_reg <= 1'b1;
            end
            seg_cnt <= seg_cnt + 5'h01;
          end
        end
        default: begin
          seg_reg <= SEG_SYNC;
          seg_cnt <= 5'h00;
        end
      endcase
    end
  end

  // Sampled bit, strobe withheld while bus-off
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_bit <= 1'b1;
      rx_bit <= 1'b1;
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= smp_fire && (node_state != NODE_BUS_OFF);
      if (smp_fire) begin
        last_bit <= smp_val;
        rx_bit <= smp_val;
      end
    end
  end

  // ****************************************
  // Error detection
  // ****************************************
  logic [2:0] run_cnt;
  logic run_lvl;
  logic [14:0] crc_reg, crc_rx;
  logic stuffed, in_stuff_zone, is_stuff_bit;
  cbted_err_t err_now;
  cbted_field_t fld;

  assign fld = frame.field;
  assign stuffed = (fld == FLD_SOF) || (fld == FLD_ARB) || (fld == FLD_CTRL) ||
                   (fld == FLD_DATA) || (fld == FLD_CRC);
  assign in_stuff_zone = stuffed || (fld == FLD_CRC_DELIM);
  assign is_stuff_bit = stuffed && (run_cnt == `CBTED_STUFF_RUN) && (smp_val != run_lvl);

  // Error conditions at the sample point
  always_comb begin
    err_now = '0;
    if (smp_fire) begin
      err_now.stuff = in_stuff_zone && (fld != FLD_SOF) &&
                      (run_cnt == `CBTED_STUFF_RUN) && (smp_val == run_lvl);
      err_now.crc = (fld == FLD_CRC_DELIM) && !frame.tx_active && (crc_rx != crc_reg);
      err_now.ack = (fld == FLD_ACK_SLOT) && frame.tx_active && smp_val;
      err_now.form = !smp_val && ((fld == FLD_CRC_DELIM) || (fld == FLD_ACK_DELIM) ||
                     (fld == FLD_EOF) || (fld == FLD_IFS));
      err_now.bit_err = frame.tx_active && (smp_val != frame.tx_level) &&
                        (fld != FLD_ERR_FRAME) &&
                        !(frame.tx_level && ((fld == FLD_ARB) || (fld == FLD_ACK_SLOT)));
    end
  end

  // Run length, CRC and received CRC sequence
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_cnt <= 3'h0;
      run_lvl <= 1'b1;
      crc_reg <= 15'h0000;
      crc_rx <= 15'h0000;
    end else if (smp_fire) begin
      if (fld == FLD_SOF || is_stuff_bit || smp_val != run_lvl) begin
        run_cnt <= 3'h1;
      end else if (run_cnt != `CBTED_STUFF_RUN) begin
        run_cnt <= run_cnt + 3'h1;
      end
      run_lvl <= smp_val;
      if (fld == FLD_SOF) begin
        crc_reg <= smp_val ? `CBTED_CRC_POLY : 15'h0000;
      end else if (!is_stuff_bit && (fld == FLD_ARB || fld == FLD_CTRL || fld == FLD_DATA)) begin
        crc_reg <= {crc_reg[13:0], 1'b0} ^ ((smp_val ^ crc_reg[14]) ? `CBTED_CRC_POLY : 15'h0000);
      end
      if (!is_stuff_bit && fld == FLD_CRC) begin
        crc_rx <= {crc_rx[13:0], smp_val};
      end
    end
  end

  // Error pulses, error frame and retransmit requests
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_flags <= '0;
      err_frame_req <= 1'b0;
      retransmit_req <= 1'b0;
    end else begin
      err_flags <= err_now;
      err_frame_req <= |err_now;
      retransmit_req <= (|err_now) && frame.tx_active;
    end
  end

  // ****************************************
  // Node state, transmit pin and clock pin
  // ****************************************
  logic clk_div;

  // Confinement state from the error counters
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      node_state <= NODE_ACTIVE;
    end else if (tx_error_count > `CBTED_BUSOFF_LIMIT) begin
      node_state <= NODE_BUS_OFF;
    end else if (tx_error_count >= `CBTED_PASSIVE_LIMIT ||
                 {1'b0, rx_error_count} >= `CBTED_PASSIVE_LIMIT) begin
      node_state <= NODE_PASSIVE;
    end else begin
      node_state <= NODE_ACTIVE;
    end
  end

  // Transmit drive, recessive is high
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_tx_pin <= 1'b1;
    end else if (node_state == NODE_BUS_OFF) begin
      bus_tx_pin <= 1'b1;
    end else if (fld == FLD_ERR_FRAME) begin
      bus_tx_pin <= (node_state == NODE_PASSIVE);
    end else if (frame.tx_active) begin
      bus_tx_pin <= frame.tx_level;
    end else begin
      bus_tx_pin <= 1'b1;
    end
  end

  // Clock pin source select
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_div <= 1'b0;
      clock_out_pin <= 1'b0;
    end else begin
      clk_div <= !clk_div;
      if (!clock_out_en) begin
        clock_out_pin <= 1'b0;
      end else begin
        clock_out_pin <= sof_sel ? (fld == FLD_SOF) : clk_div;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_cfg_lock: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_wr && !cfg_mode) |=> ($stable(cfg1_reg) && $stable(cfg2_reg) && $stable(cfg3_reg)))
    else $error("config changed outside config mode");
  chk_ext_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ext_reg <= sjw_len) else $error("phase-one lengthened past jump width");
  chk_ps2_floor: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !ph2_src |-> (ps2_base >= `CBTED_IPT_TQ && ps2_base >= ph1_len))
    else $error("phase-two below processing time");
  chk_stuff_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (smp_fire && fld == FLD_DATA && run_cnt == `CBTED_STUFF_RUN && smp_val == run_lvl)
    |=> (err_flags.stuff && err_frame_req)) else $error("stuff error missed");
  chk_ack_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (smp_fire && fld == FLD_ACK_SLOT && frame.tx_active && smp_val)
    |=> (err_flags.ack && retransmit_req)) else $error("acknowledge error missed");
  chk_arb_exempt: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (smp_fire && fld == FLD_ARB && frame.tx_level && !smp_val) |=> !err_flags.bit_err)
    else $error("bit error raised during arbitration");
  chk_busoff_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (node_state == NODE_BUS_OFF) |=> (bus_tx_pin && !sample_strobe))
    else $error("bus-off node still active");
  chk_passive_frame: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (node_state == NODE_PASSIVE && fld == FLD_ERR_FRAME) |=> bus_tx_pin)
    else $error("passive node drove dominant error frame");
  chk_tq_spacing: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tq_tick && !cfg_mode) |=> (!tq_tick || hard_sync)[*1])
    else $error("quantum tick too close");
  cov_hard_sync: cover property (@(posedge ref_clk) disable iff (!rst_b) hard_sync);
  cov_triple: cover property (@(posedge ref_clk) disable iff (!rst_b) smp_fire && triple_sel);
  cov_crc_err: cover property (@(posedge ref_clk) disable iff (!rst_b) err_now.crc);
  cov_shrink: cover property (@(posedge ref_clk) disable iff (!rst_b) shrink_reg != 5'h00);

endmodule : cbted_core

//--- core/cbted_regs.svh
`ifndef CBTED_REGS_SVH
`define CBTED_REGS_SVH
// Register offsets
`define CBTED_CFG3_ADDR 8'h28
`define CBTED_CFG2_ADDR 8'h29
`define CBTED_CFG1_ADDR 8'h2A
`define CBTED_CFG_RESET 8'h00
`define CBTED_CFG3_MASK 8'hC7
// Field positions
`define CBTED_PRESCALE_LSB 0
`define CBTED_SJW_LSB 6
`define CBTED_PROP_LSB 0
`define CBTED_PH1_LSB 3
`define CBTED_TRIPLE_BIT 6
`define CBTED_PH2SRC_BIT 7
`define CBTED_PH2_LSB 0
`define CBTED_WAKEFILT_BIT 6
`define CBTED_SOFSEL_BIT 7
// Timing and limits
`define CBTED_IPT_TQ 5'h02
`define CBTED_STUFF_RUN 3'h5
`define CBTED_PASSIVE_LIMIT 9'h080
`define CBTED_BUSOFF_LIMIT 9'h0FF
`define CBTED_WAKE_FILT_CYC 3'h4
`define CBTED_CRC_POLY 15'h4599
`endif

//--- core/cbted_pkg.sv
package cbted_pkg;
  // Frame field reported by the protocol engine
  typedef enum logic [3:0] {
    FLD_IDLE = 4'h0, FLD_SOF = 4'h1, FLD_ARB = 4'h2, FLD_CTRL = 4'h3,
    FLD_DATA = 4'h4, FLD_CRC = 4'h5, FLD_CRC_DELIM = 4'h6, FLD_ACK_SLOT = 4'h7,
    FLD_ACK_DELIM = 4'h8, FLD_EOF = 4'h9, FLD_IFS = 4'hA, FLD_ERR_FRAME = 4'hB
  } cbted_field_t;
  typedef enum logic [2:0] {
    NODE_ACTIVE = 3'b001, NODE_PASSIVE = 3'b010, NODE_BUS_OFF = 3'b100
  } cbted_node_t;
  typedef enum logic [2:0] {
    SEG_SYNC = 3'b001, SEG_TSEG1 = 3'b010, SEG_PS2 = 3'b100
  } cbted_seg_t;
  typedef struct packed {
    logic crc;
    logic ack;
    logic form;
    logic bit_err;
    logic stuff;
  } cbted_err_t;
  typedef struct packed {
    cbted_field_t field;
    logic tx_active;
    logic tx_level;
    logic bus_idle;
  } cbted_frame_t;
endpackage : cbted_pkg

//--- sim/cbted_bus_node.sv
// ********
// Far-side node on the shared bus
// ********
module cbted_bus_node (
  input wire logic dut_tx,
  input wire logic drive_dom,
  input wire logic rx_open,
  output logic bus_rx
);
  timeunit 1ns;
  timeprecision 100ps;

  // Wired-AND with pull-up: dominant from either node wins
  // Open receive path reads recessive, used only as a commanded fault
  assign bus_rx = rx_open ? 1'b1 : (dut_tx & ~drive_dom);
endmodule : cbted_bus_node

//--- sim/can_bit_timing_and_error_detect_test.sv
module can_bit_timing_and_error_detect_test
  import cbted_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ********
  // Signals and stimulus tables
  // ********
  logic ref_clk, rst_b, cfg_mode, reg_wr, reg_rd, clock_out_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_error_count;
  logic [8:0] tx_error_count;
  logic bus_rx_pin, bus_tx_pin, clock_out_pin, sample_strobe, rx_bit;
  logic err_frame_req, retransmit_req, wake_event, node_dom, rx_open;
  logic efr, rtr, lst;
  cbted_frame_t frame;
  cbted_err_t err_flags, ef;
  cbted_node_t node_state;
  int fails, n_tests, run, i, n;
  // Timing configs, slowest first, with expected bit length in clocks
  logic [7:0] c1[4] = '{8'h3F, 8'h41, 8'h00, 8'h00};
  logic [7:0] c2[4] = '{8'h00, 8'h19, 8'hCA, 8'h00};
  logic [7:0] c3[4] = '{8'h00, 8'h00, 8'h02, 8'h00};
  int bt[4] = '{640, 44, 18, 10};
  // Transmit cases: field, tx level, far dominant, open rx, flags
  logic [11:0] tv[5] = '{{4'h4, 3'h6, 5'h02}, {4'h2, 3'h6, 5'h00},
    {4'h7, 3'h6, 5'h00}, {4'h7, 3'h4, 5'h08}, {4'h4, 3'h1, 5'h02}};
  cbted_field_t ff[4] = '{FLD_EOF, FLD_IFS, FLD_ACK_DELIM, FLD_CRC_DELIM};
  logic [8:0] tx_cnt_v[5] = '{9'h07F, 9'h000, 9'h080, 9'h0FF, 9'h100};
  logic [7:0] rx_cnt_v[5] = '{8'h7F, 8'h80, 8'h00, 8'h00, 8'h00};
  cbted_node_t ns_v[5] = '{NODE_ACTIVE, NODE_PASSIVE, NODE_PASSIVE,
    NODE_PASSIVE, NODE_BUS_OFF};

  cbted_core cbted_core_inst (.ref_clk, .rst_b, .cfg_mode, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .bus_rx_pin, .bus_tx_pin, .frame, .tx_error_count,
    .rx_error_count, .clock_out_en, .clock_out_pin, .sample_strobe, .rx_bit,
    .err_flags, .err_frame_req, .retransmit_req, .node_state, .wake_event);

  cbted_bus_node cbted_bus_node_inst (.dut_tx(bus_tx_pin), .drive_dom(node_dom),
    .rx_open(rx_open), .bus_rx(bus_rx_pin));

  // ********
  // Tasks
  // ********
  task conclude();
    $display("Mismatches %0d, checks %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d, input logic m = 1'b1);
    @(posedge ref_clk);
    cfg_mode <= m;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  // Bounded wait for the next sample strobe
  task ws();
    for (int k = 0; k < 1000; k++) begin
      @(posedge ref_clk);
      #1;
      if (sample_strobe === 1'b1) return;
    end
    fails++;
    conclude();
  endtask : ws

  task per(output int m);
    ws();
    for (m = 1; m < 1000; m++) begin
      @(posedge ref_clk);
      #1;
      if (sample_strobe === 1'b1) return;
    end
    fails++;
    conclude();
  endtask : per

  // One bit: set inputs early in phase two, capture pulses at next sample
  task bs(input cbted_field_t f, input logic ta, tl, nd, op = 1'b0);
    @(posedge ref_clk);
    frame <= '{f, ta, tl, f == FLD_IDLE};
    node_dom <= nd;
    rx_open <= op;
    ws();
    ef = err_flags;
    efr = err_frame_req;
    rtr = retransmit_req;
  endtask : bs

  task idle();
    ws();
    bs(FLD_IDLE, 1'b0, 1'b1, 1'b0);
    bs(FLD_IDLE, 1'b0, 1'b1, 1'b0);
  endtask : idle

  // Received bit from the far node, stuffing after five equal bits
  task sb(input cbted_field_t f, input logic l);
    bs(f, 1'b0, 1'b1, !l);
    run = (l === lst) ? run + 1 : 1;
    lst = l;
    if (run == 5) begin
      bs(f, 1'b0, 1'b1, l);
      lst = !l;
      run = 1;
    end
  endtask : sb

  task rxf(input logic bad);
    logic [14:0] c;
    logic [10:0] s;
    logic x;
    c = 15'h0000;
    s = 11'h2AA;
    run = 0;
    lst = 1'b1;
    idle();
    for (int k = 10; k >= 0; k--) begin
      x = s[k] ^ c[14];
      c = {c[13:0], 1'b0} ^ (x ? 15'h4599 : 15'h0000);
      sb((k == 10) ? FLD_SOF : FLD_DATA, s[k]);
    end
    c[0] = c[0] ^ bad;
    for (int k = 14; k >= 0; k--) sb(FLD_CRC, c[k]);
    bs(FLD_CRC_DELIM, 1'b0, 1'b1, 1'b0);
    chk({ef, efr}, {bad, 4'h0, bad});
  endtask : rxf

  task wk(input int len, input logic e);
    logic s;
    s = 1'b0;
    @(posedge ref_clk);
    node_dom <= 1'b1;
    for (int k = 0; k < len + 12; k++) begin
      @(posedge ref_clk);
      if (k == len - 1) node_dom <= 1'b0;
      #1;
      s = s | wake_event;
    end
    chk(s, e);
  endtask : wk

  task cs(input cbted_field_t f, input logic e);
    @(posedge ref_clk);
    frame <= '{f, 1'b0, 1'b1, f == FLD_IDLE};
    repeat (2) @(posedge ref_clk);
    #1;
    chk(clock_out_pin, e);
  endtask : cs

  // ********
  // Clock and main sequence
  // ********
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    rst_b = 1'b0;
    {cfg_mode, reg_wr, reg_rd, clock_out_en, node_dom, rx_open} = 6'h00;
    {reg_addr, reg_wdata, rx_error_count, tx_error_count} = 33'h0;
    frame = '{FLD_IDLE, 1'b0, 1'b1, 1'b1};
    fails = 0;
    n_tests = 0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Reset values, unmapped place, reserved bits, write lock
    for (i = 0; i < 4; i++) rd(8'h28 + i[7:0], 8'h00);
    wr(8'h2B, 8'hFF);
    rd(8'h2B, 8'h00);
    wr(8'h28, 8'hFF);
    rd(8'h28, 8'hC7);
    wr(8'h29, 8'hA5);
    wr(8'h2A, 8'h5A);
    wr(8'h2A, 8'h00, 1'b0);
    rd(8'h29, 8'hA5);
    rd(8'h2A, 8'h5A);
    // Bit length for each timing config
    for (i = 0; i < 4; i++) begin
      wr(8'h2A, c1[i]);
      wr(8'h29, c2[i]);
      wr(8'h28, c3[i]);
      wr(8'h2B, 8'h00, 1'b0);
      per(n);
      per(n);
      chk(n[15:0], bt[i][15:0]);
    end
    // Transmit read-back and acknowledge cases
    for (i = 0; i < 5; i++) begin
      idle();
      bs(FLD_SOF, 1'b1, 1'b0, 1'b0); // Own start bit ends the idle run
      bs(cbted_field_t'(tv[i][11:8]), 1'b1, tv[i][7], tv[i][6], tv[i][5]);
      chk({ef, efr, rtr}, {tv[i][4:0], |tv[i][4:0], |tv[i][4:0]});
    end
    // Dominant in fixed-form fields
    for (i = 0; i < 4; i++) begin
      idle();
      bs(ff[i], 1'b0, 1'b1, 1'b1);
      chk({ef.form, efr, rtr}, 3'h6);
    end
    // Six equal bits after a recessive one
    idle();
    bs(FLD_SOF, 1'b0, 1'b1, 1'b1);
    bs(FLD_DATA, 1'b0, 1'b1, 1'b0);
    for (i = 1; i < 7; i++) begin
      bs(FLD_DATA, 1'b0, 1'b1, 1'b1);
      chk(ef, (i == 6) ? 5'h01 : 5'h00);
      chk(rx_bit, 1'b0);
    end
    rxf(1'b0);
    rxf(1'b1);
    // Error frame polarity by node state
    idle();
    bs(FLD_ERR_FRAME, 1'b1, 1'b0, 1'b0);
    chk(bus_tx_pin, 1'b0);
    @(posedge ref_clk);
    tx_error_count <= 9'h080;
    bs(FLD_ERR_FRAME, 1'b1, 1'b0, 1'b0);
    chk(bus_tx_pin, 1'b1);
    bs(FLD_DATA, 1'b1, 1'b0, 1'b0);
    chk(bus_tx_pin, 1'b0);
    bs(FLD_IDLE, 1'b0, 1'b1, 1'b0);
    // Clock pin: off, divided clock, start-of-frame
    n = 0;
    repeat (8) begin
      @(posedge ref_clk);
      #1;
      n += (clock_out_pin !== 1'b0);
    end
    chk(n[15:0], 16'h0000);
    @(posedge ref_clk);
    clock_out_en <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    n = 0;
    repeat (8) begin
      lst = clock_out_pin;
      @(posedge ref_clk);
      #1;
      n += (clock_out_pin === lst);
    end
    chk(n[15:0], 16'h0000);
    wr(8'h28, 8'h80);
    wr(8'h2B, 8'h00, 1'b0);
    cs(FLD_SOF, 1'b1);
    cs(FLD_IDLE, 1'b0);
    // Wake filter on, then off
    wr(8'h28, 8'h40);
    wr(8'h2B, 8'h00, 1'b0);
    wk(2, 1'b0);
    wk(8, 1'b1);
    wr(8'h28, 8'h00);
    wr(8'h2B, 8'h00, 1'b0);
    wk(2, 1'b1);
    // Node state thresholds, ending in bus-off
    for (i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      tx_error_count <= tx_cnt_v[i];
      rx_error_count <= rx_cnt_v[i];
      repeat (2) @(posedge ref_clk);
      #1;
      chk(node_state, ns_v[i]);
    end
    @(posedge ref_clk);
    frame <= '{FLD_DATA, 1'b1, 1'b0, 1'b0};
    n = 0;
    repeat (300) begin
      @(posedge ref_clk);
      #1;
      n += (sample_strobe !== 1'b0) + (bus_tx_pin !== 1'b1);
    end
    chk(n[15:0], 16'h0000);
    conclude();
  end
endmodule : can_bit_timing_and_error_detect_test
